// ==== design/ehtap_coef_reg.sv ====
// one tap: software copy of the coefficient and the copy the filter uses
// assumes the top decodes the bus and gives one write strobe per tap
`timescale 1ns/1ps
`default_nettype none
module ehtap_coef_reg
  import ehtap_pkg::*;
(
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // software side
  input  wire logic              wr_en,
  input  wire logic [COEF_W-1:0] wr_data,
  input  wire logic              apply_now,
  output logic      [COEF_W-1:0] coef,
  output logic                   pending,
  // filter side
  output logic      [COEF_W-1:0] active_coef,
  output logic                   stage_on
);

  logic [COEF_W-1:0] next_coef;
  logic [COEF_W-1:0] next_active;
  logic              next_pending;

  always_comb begin
    next_coef    = coef;
    next_active  = active_coef;
    next_pending = pending;
    if (wr_en) begin
      next_coef = wr_data;
    end
    // write in the same cycle as apply goes straight through, never lost
    if (apply_now) begin
      next_active  = next_coef;
      next_pending = 1'b0;
    end else if (wr_en) begin
      next_pending = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      coef        <= RST_COEF;
      active_coef <= RST_COEF;
      pending     <= 1'b0;
    end else begin
      coef        <= next_coef;
      active_coef <= next_active;
      pending     <= next_pending;
    end
  end

  // all-zero coefficient means the stage adds nothing
  assign stage_on = |active_coef;

endmodule // ehtap_coef_reg
`default_nettype wire

// ==== design/ehtap_pkg.sv ====
// constants for the echo hybrid tap one to four coefficient block
// assumes an apb slave with 32-bit data and byte addresses four times the index
package ehtap_pkg;

  // widths
  localparam int unsigned COEF_W   = 8;
  localparam int unsigned ADDR_W   = 8;
  localparam int unsigned DATA_W   = 32;
  localparam int unsigned NUM_TAPS = 4;

  // register indices, byte address is four times the index
  localparam logic [7:0] IDX_TAP1 = 8'h2D;
  localparam logic [7:0] IDX_TAP2 = 8'h2E;
  localparam logic [7:0] IDX_TAP3 = 8'h2F;
  localparam logic [7:0] IDX_TAP4 = 8'h30;
  localparam logic [7:0] IDX_CTRL = 8'h31;
  localparam logic [7:0] IDX_STAT = 8'h32;

  localparam logic [ADDR_W-1:0] ADDR_TAP1 = {IDX_TAP1[5:0], 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_TAP2 = {IDX_TAP2[5:0], 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_TAP3 = {IDX_TAP3[5:0], 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_TAP4 = {IDX_TAP4[5:0], 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_CTRL = {IDX_CTRL[5:0], 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_STAT = {IDX_STAT[5:0], 2'b00};

  // reset values
  localparam logic [COEF_W-1:0] RST_COEF = 8'h00;
  localparam logic              RST_IMMEDIATE = 1'b0;

  // control fields
  localparam int unsigned CTRL_IMMEDIATE_BIT = 0;

  // status fields
  localparam int unsigned STAT_PENDING_LSB = 0;
  localparam int unsigned STAT_ACTIVE_LSB  = 4;

  // tap selector
  typedef enum logic [2:0] {
    EHTAP_SEL_NONE,
    EHTAP_SEL_TAP1,
    EHTAP_SEL_TAP2,
    EHTAP_SEL_TAP3,
    EHTAP_SEL_TAP4,
    EHTAP_SEL_CTRL,
    EHTAP_SEL_STAT
  } ehtap_sel_t;

endpackage

// ==== design/ehtap_top.sv ====
// apb register block holding the coefficients of hybrid taps one to four
// assumes apb with 32-bit data, zero wait states and a sample strobe from the filter
//
// Summary of operation
// - software writes an 8-bit coefficient per tap
// - first tap register drives filter tap one
// - second tap register drives filter tap two
// - third tap register drives filter tap three
// - fourth tap register drives filter tap four
// - zero coefficient makes its stage contribute nothing
`timescale 1ns/1ps
`default_nettype none
module ehtap_top
  import ehtap_pkg::*;
(
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  // filter side
  input  wire logic              sample_strobe,
  output logic      [COEF_W-1:0] tap_one_coefficient,
  output logic      [COEF_W-1:0] tap_two_coefficient,
  output logic      [COEF_W-1:0] tap_three_coefficient,
  output logic      [COEF_W-1:0] tap_four_coefficient,
  output logic      [3:0]        tap_stage_on
);

  ehtap_sel_t        sel;
  logic              setup_phase;
  logic              access_wr;
  logic              low_lane;
  logic [3:0]        tap_wr;
  logic [COEF_W-1:0] coef_rd [NUM_TAPS];
  logic [COEF_W-1:0] coef_act [NUM_TAPS];
  logic [3:0]        tap_pending;
  logic              apply_now;
  logic              immediate;
  logic              next_immediate;
  logic [DATA_W-1:0] next_prdata;
  logic              next_pslverr;

  // no wait states; every transfer completes on its first access cycle
  assign pready      = 1'b1;
  assign setup_phase = psel && !penable;
  assign access_wr   = psel && penable && pwrite;
  assign low_lane    = pstrb[0];

  // address decode
  always_comb begin
    if (paddr == ADDR_TAP1) begin
      sel = EHTAP_SEL_TAP1;
    end else if (paddr == ADDR_TAP2) begin
      sel = EHTAP_SEL_TAP2;
    end else if (paddr == ADDR_TAP3) begin
      sel = EHTAP_SEL_TAP3;
    end else if (paddr == ADDR_TAP4) begin
      sel = EHTAP_SEL_TAP4;
    end else if (paddr == ADDR_CTRL) begin
      sel = EHTAP_SEL_CTRL;
    end else if (paddr == ADDR_STAT) begin
      sel = EHTAP_SEL_STAT;
    end else begin
      sel = EHTAP_SEL_NONE;
    end
  end

  // one strobe per tap keeps the other taps untouched
  always_comb begin
    tap_wr = 4'h0;
    if (access_wr && low_lane) begin
      case (sel)
        EHTAP_SEL_TAP1: tap_wr[0] = 1'b1;
        EHTAP_SEL_TAP2: tap_wr[1] = 1'b1;
        EHTAP_SEL_TAP3: tap_wr[2] = 1'b1;
        EHTAP_SEL_TAP4: tap_wr[3] = 1'b1;
        default:        tap_wr    = 4'h0;
      endcase
    end
  end

  // control: immediate mode lets writes reach the filter without a sample
  always_comb begin
    next_immediate = immediate;
    if (access_wr && low_lane && (sel == EHTAP_SEL_CTRL)) begin
      next_immediate = pwdata[CTRL_IMMEDIATE_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      immediate <= RST_IMMEDIATE;
    end else begin
      immediate <= next_immediate;
    end
  end

  // updating only at sample boundaries, unless immediate is set, avoids a coefficient changing mid-sample
  assign apply_now = sample_strobe || immediate;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_TAPS; gi++) begin : g_tap
      ehtap_coef_reg u_coef (
        .pclk        (pclk),
        .presetn     (presetn),
        .wr_en       (tap_wr[gi]),
        .wr_data     (pwdata[COEF_W-1:0]),
        .apply_now   (apply_now),
        .coef        (coef_rd[gi]),
        .pending     (tap_pending[gi]),
        .active_coef (coef_act[gi]),
        .stage_on    (tap_stage_on[gi])
      );
    end
  endgenerate

  // coefficients to the filter, flop outputs of each tap
  assign tap_one_coefficient   = coef_act[0];
  assign tap_two_coefficient   = coef_act[1];
  assign tap_three_coefficient = coef_act[2];
  assign tap_four_coefficient  = coef_act[3];

  // read data captured in setup so prdata comes from a flop
  always_comb begin
    next_prdata  = prdata;
    next_pslverr = pslverr;
    if (setup_phase) begin
      next_prdata  = '0;
      next_pslverr = 1'b0;
      case (sel)
        EHTAP_SEL_TAP1: next_prdata[COEF_W-1:0] = coef_rd[0];
        EHTAP_SEL_TAP2: next_prdata[COEF_W-1:0] = coef_rd[1];
        EHTAP_SEL_TAP3: next_prdata[COEF_W-1:0] = coef_rd[2];
        EHTAP_SEL_TAP4: next_prdata[COEF_W-1:0] = coef_rd[3];
        EHTAP_SEL_CTRL: next_prdata[CTRL_IMMEDIATE_BIT] = immediate;
        EHTAP_SEL_STAT: begin
          next_prdata[STAT_PENDING_LSB +: NUM_TAPS] = tap_pending;
          next_prdata[STAT_ACTIVE_LSB  +: NUM_TAPS] = tap_stage_on;
        end
        default:        next_pslverr = 1'b1;
      endcase
      // status is read only; a write there is flagged
      if (pwrite && (sel == EHTAP_SEL_STAT)) begin
        next_pslverr = 1'b1;
      end
      if (pwrite) begin
        next_prdata = '0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= '0;
      pslverr <= 1'b0;
    end else begin
      prdata  <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

endmodule // ehtap_top
`default_nettype wire

// ==== test/ehtap_asserts.sv ====
// port checker for the tap coefficient block
// assumes it is bound onto ehtap_top
`timescale 1ns/1ps
`default_nettype none
module ehtap_asserts
  import ehtap_pkg::*;
(
  // clock and reset
  input wire logic              pclk,
  input wire logic              presetn,
  // apb
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic [DATA_W-1:0] prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  // filter side
  input wire logic              sample_strobe,
  input wire logic [COEF_W-1:0] tap_one_coefficient,
  input wire logic [COEF_W-1:0] tap_two_coefficient,
  input wire logic [COEF_W-1:0] tap_three_coefficient,
  input wire logic [COEF_W-1:0] tap_four_coefficient,
  input wire logic [3:0]        tap_stage_on
);
  // quiet for one edge after reset: the async clear lands between two samples
  logic rst_hold;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_hold <= 1'b1;
    end else begin
      rst_hold <= 1'b0;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn || rst_hold);
  logic wr;
  assign wr = psel && penable && pwrite;
  tap_read_a: assert property (psel && !penable && !pwrite && paddr == ADDR_TAP1
    |=> !pslverr && prdata[31:8] == 24'h000000) else $error("tap read bad");
  tap_one_src_a: assert property ($changed(tap_one_coefficient)
    |-> $past(sample_strobe || wr && paddr == ADDR_TAP1)) else $error("tap one moved");
  tap_two_src_a: assert property ($changed(tap_two_coefficient)
    |-> $past(sample_strobe || wr && paddr == ADDR_TAP2)) else $error("tap two moved");
  tap_three_src_a: assert property ($changed(tap_three_coefficient)
    |-> $past(sample_strobe || wr && paddr == ADDR_TAP3)) else $error("tap three moved");
  tap_four_src_a: assert property ($changed(tap_four_coefficient)
    |-> $past(sample_strobe || wr && paddr == ADDR_TAP4)) else $error("tap four moved");
  zero_stage_a: assert property (tap_stage_on == {|tap_four_coefficient,
    |tap_three_coefficient, |tap_two_coefficient, |tap_one_coefficient}) else $error("stage bad");
  others_hold_a: assert property (wr && paddr == ADDR_TAP1 && !sample_strobe |=>
    $stable({tap_two_coefficient, tap_three_coefficient, tap_four_coefficient}))
    else $error("taps disturbed");
endmodule // ehtap_asserts
bind ehtap_top ehtap_asserts ehtap_asserts_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pstrb, .prdata, .pready, .pslverr, .sample_strobe, .tap_one_coefficient,
  .tap_two_coefficient, .tap_three_coefficient, .tap_four_coefficient, .tap_stage_on);
`default_nettype wire

// ==== test/test_ehtap_top.sv ====
// self-checking bench for the tap coefficient block
// assumes the apb map and strobe timing of ehtap_pkg
`timescale 1ns/1ps
`default_nettype none
module test_ehtap_top
  import ehtap_pkg::*;
;
  logic              pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, sample_strobe = 0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0, prdata, seed = 32'h0000001D;
  logic [3:0]        pstrb = '0, tap_stage_on;
  logic              pready, pslverr;
  logic [COEF_W-1:0] t1, t2, t3, t4, c [4], p [4];
  logic [7:0]        ad [4] = '{ADDR_TAP1, ADDR_TAP2, ADDR_TAP3, ADDR_TAP4};
  logic [32:0]       expq [$];
  int                fail_count = 0, comparisons = 0;
  always #20 pclk = ~pclk;
  ehtap_top ehtap_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .sample_strobe, .tap_one_coefficient(t1),
    .tap_two_coefficient(t2), .tap_three_coefficient(t3), .tap_four_coefficient(t4),
    .tap_stage_on);
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [32:0] e, input logic [32:0] a);
    comparisons++;
    if (a !== e) begin
      fail_count++;
      $display("mismatch at %0t: exp %h got %h", $time, e, a);
    end
  endtask
  task automatic results();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // idle cycle after each transfer: no signal assigned twice in one step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (pready !== 1'h1) begin
      fail_count++;
      results();
    end
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    expq.push_back(e);
    apb(1'h0, a, 32'h0, 4'h0);
  endtask
  task automatic tapchk();
    chk({1'h0, c[3], c[2], c[1], c[0]}, {1'h0, t4, t3, t2, t1});
    chk({29'h0, |c[3], |c[2], |c[1], |c[0]}, {29'h0, tap_stage_on});
  endtask
  always @(posedge pclk) if (psel && penable && pready === 1'h1 && !pwrite) begin
    if (expq.size() > 0) chk(expq.pop_front(), {pslverr, prdata});
    else begin
      fail_count++;
      $display("mismatch at %0t: exp %h got %h", $time, 33'h0, {pslverr, prdata});
    end
  end
  initial begin
    logic [31:0] d;
    c = '{default: 8'h00};
    repeat (10) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    for (int i = 0; i < 4; i++) rd(ad[i], 33'h0);
    tapchk();
    for (int k = 0; k < 3; k++) begin
      for (int i = 0; i < 4; i++) begin
        d = rnd();
        if (k == 1 && i == 1) d = 32'h0;
        apb(1'h1, ad[i], d, 4'h1);
        p[i] = d[7:0];
        tapchk();
      end
      for (int i = 0; i < 4; i++) rd(ad[i], {25'h0, p[i]});
      rd(ADDR_STAT, {25'h0, |c[3], |c[2], |c[1], |c[0], 4'hF});
      sample_strobe <= 1'h1;
      @(posedge pclk);
      sample_strobe <= 1'h0;
      @(posedge pclk);
      c = p;
      tapchk();
    end
    apb(1'h1, ad[0], 32'h000000FF, 4'h0);
    rd(ad[0], {25'h0, p[0]});
    rd(8'h00, 33'h100000000);
    apb(1'h1, ADDR_CTRL, 32'h00000001, 4'h1);
    rd(ADDR_CTRL, 33'h000000001);
    p[2] = 8'hA5;
    apb(1'h1, ADDR_TAP3, 32'h000000A5, 4'h1);
    c = p;
    tapchk();
    presetn <= 1'h0;
    @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    c = '{default: 8'h00};
    tapchk();
    rd(ADDR_CTRL, 33'h000000000);
    repeat (2) @(posedge pclk);
    results();
  end
endmodule // test_ehtap_top
`default_nettype wire
